//--- inc/difm_pkg.sv
// difm_pkg: function codes and constants of the digital input mapper
// assumes: included before the mapper module, single clock domain
`default_nettype none

package difm_pkg;

    localparam int DIFM_NUM_IN = 8;
    localparam int DIFM_CODE_W = 8;

    // input function codes
    localparam logic [7:0] FC_SERVO_ENABLE = 8'h01;
    localparam logic [7:0] FC_FAULT_CLEAR = 8'h02;
    localparam logic [7:0] FC_GAIN_SWITCH = 8'h03;
    localparam logic [7:0] FC_PULSE_COUNTER_CLEAR = 8'h04;
    localparam logic [7:0] FC_LOW_SPEED_HOLD = 8'h05;
    localparam logic [7:0] FC_CMD_DIR_INVERT = 8'h06;
    localparam logic [7:0] FC_RESERVED_07 = 8'h07;
    localparam logic [7:0] FC_COMMAND_TRIGGER = 8'h08;
    localparam logic [7:0] FC_TORQUE_LIMIT_ENABLE = 8'h09;
    localparam logic [7:0] FC_SPEED_LIMIT_ENABLE = 8'h10;
    localparam logic [7:0] FC_TARGET_SEL_B0 = 8'h11;
    localparam logic [7:0] FC_TARGET_SEL_B1 = 8'h12;
    localparam logic [7:0] FC_TARGET_SEL_B2 = 8'h13;
    localparam logic [7:0] FC_VEL_SRC_B0 = 8'h14;
    localparam logic [7:0] FC_VEL_SRC_B1 = 8'h15;
    localparam logic [7:0] FC_FORCE_SRC_B0 = 8'h16;
    localparam logic [7:0] FC_FORCE_SRC_B1 = 8'h17;
    localparam logic [7:0] FC_SPEED_POS_SW = 8'h18;
    localparam logic [7:0] FC_SPEED_TORQUE_SW = 8'h19;
    localparam logic [7:0] FC_TORQUE_POS_SW = 8'h20;
    localparam logic [7:0] FC_OPERATIONAL_HALT = 8'h21;
    localparam logic [7:0] FC_REVERSE_TRAVEL_LIMIT = 8'h22;
    localparam logic [7:0] FC_FORWARD_TRAVEL_LIMIT = 8'h23;
    localparam logic [7:0] FC_ORIGIN_SENSOR = 8'h24;
    localparam logic [7:0] FC_REVERSE_FORCE_LIMIT = 8'h25;
    localparam logic [7:0] FC_FORWARD_FORCE_LIMIT = 8'h26;
    localparam logic [7:0] FC_GO_TO_ORIGIN = 8'h27;
    localparam logic [7:0] FC_PULSE_OR_STORED_SW = 8'h2A;
    localparam logic [7:0] FC_INCH_FORWARD = 8'h37;
    localparam logic [7:0] FC_INCH_REVERSE = 8'h38;
    localparam logic [7:0] FC_GEAR_NUM_SEL_B0 = 8'h43;
    localparam logic [7:0] FC_GEAR_NUM_SEL_B1 = 8'h44;
    localparam logic [7:0] FC_PULSE_INPUT_BLOCK = 8'h45;
    localparam logic [7:0] FC_MOTOR_STOP = 8'h46;

    // base control modes as configured
    typedef enum logic [3:0] {
        MODE_PT,
        MODE_PR,
        MODE_S,
        MODE_T,
        MODE_SZ,
        MODE_TZ,
        MODE_PT_S,
        MODE_PT_T,
        MODE_PR_S,
        MODE_PR_T,
        MODE_S_T
    } difm_mode_t;

    // effective loop in force after the switch inputs
    typedef enum logic [1:0] {
        LOOP_POSITION,
        LOOP_SPEED,
        LOOP_TORQUE
    } difm_loop_t;

    localparam logic [2:0] ALARM_RESET = 3'h0;
    localparam logic [1:0] SEL2_RESET = 2'h0;
    localparam logic [2:0] SEL3_RESET = 3'h0;

endpackage : difm_pkg

`default_nettype wire

//--- verilog/difm_mapper.sv
// difm_mapper: digital inputs to drive control functions by code
// assumes: inputs synchronous to clock_i, codes held stable by config
`default_nettype none

// What this block does
// R01 - decode basic input function codes 0x01..0x10
// R02 - codes 0x14/0x15 pick speed source
// R03 - codes 0x16/0x17 pick torque source
// R04 - code 0x2A in MODE_PT: off pulse, on stored
// R05 - force limit inputs gated by enable parameter
// R06 - go-to-origin in stored mode commands homing
// R07 - forward inch active in any mode
// R08 - reverse inch active in any mode
// R09 - pulse block drops external pulses in position
// R10 - two gear inputs pick numerator setting in position
// R11 - user assigns codes to the eight inputs
// R12 - switch inputs pick speed, torque, position loop
// R13 - three select inputs pick stored target
// R14 - halt and travel limits alarm when inactive
// R15 - reserved or unknown codes drive nothing
// R16 - inputs synchronised before decode
module difm_mapper
    import difm_pkg::*;
#(
    parameter int NUM_IN = DIFM_NUM_IN
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // physical inputs and assignment codes
    input wire logic [NUM_IN-1:0] din_i,
    input wire logic [NUM_IN*DIFM_CODE_W-1:0] assign_codes_i,
    // configuration
    input wire difm_mode_t base_mode_i,
    input wire logic force_limit_enable_param_i,
    // basic functions
    output logic servo_enable_o,
    output logic fault_clear_o,
    output logic gain_switch_o,
    output logic pulse_counter_clear_o,
    output logic low_speed_hold_o,
    output logic command_direction_invert_o,
    output logic command_trigger_o,
    output logic torque_limit_enable_o,
    output logic speed_limit_enable_o,
    output logic motor_stop_o,
    output logic origin_sensor_o,
    // selectors and modes
    output logic [1:0] velocity_source_sel_o,
    output logic [1:0] force_source_sel_o,
    output logic [2:0] stored_target_sel_o,
    output logic [1:0] gear_numerator_sel_o,
    output logic stored_target_mode_o,
    output difm_loop_t active_loop_o,
    // motion requests
    output logic reverse_force_limit_o,
    output logic forward_force_limit_o,
    output logic go_to_origin_o,
    output logic inch_forward_o,
    output logic inch_reverse_o,
    output logic pulse_input_block_o,
    // alarms: halt, reverse limit, forward limit
    output logic [2:0] alarm_o
);

    logic [NUM_IN-1:0] sync0_r, sync0_nxt;
    logic [NUM_IN-1:0] sync1_r, sync1_nxt;
    logic [NUM_IN-1:0] hit [0:255];
    logic [255:0] func;
    logic [2:0] alarm_r, alarm_nxt;
    logic [1:0] vel_r, vel_nxt, frc_r, frc_nxt, gear_r, gear_nxt;
    logic [2:0] tgt_r, tgt_nxt;
    logic stored_r, stored_nxt;
    difm_loop_t loop_r, loop_nxt;
    logic [10:0] flags_r, flags_nxt;
    logic [5:0] mot_r, mot_nxt;
    logic pos_mode;

    // input synchroniser
    always_comb begin
        sync0_nxt = din_i; // see R16
        sync1_nxt = sync0_r;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync0_r <= '0;
            sync1_r <= '0;
        end else if (ce_i) begin
            sync0_r <= sync0_nxt;
            sync1_r <= sync1_nxt;
        end
    end

    // per-code OR of all inputs carrying that code
    genvar gc, gi;
    generate
        for (gc = 0; gc < 256; gc++) begin : g_code
            for (gi = 0; gi < NUM_IN; gi++) begin : g_in
                assign hit[gc][gi] = sync1_r[gi] &&
                    (assign_codes_i[gi*DIFM_CODE_W +: DIFM_CODE_W]
                     == 8'(gc)); // see R11
            end
            assign func[gc] = |hit[gc];
        end
    endgenerate

    // next state of all decoded functions
    always_comb begin
        flags_nxt = {
            func[FC_ORIGIN_SENSOR],
            func[FC_MOTOR_STOP],
            func[FC_SPEED_LIMIT_ENABLE],
            func[FC_TORQUE_LIMIT_ENABLE],
            func[FC_COMMAND_TRIGGER],
            func[FC_CMD_DIR_INVERT],
            func[FC_LOW_SPEED_HOLD],
            func[FC_PULSE_COUNTER_CLEAR],
            func[FC_GAIN_SWITCH],
            func[FC_FAULT_CLEAR],
            func[FC_SERVO_ENABLE]
        }; // see R01
        // only listed codes are read; others and 0x07 go nowhere
        // see R15
        vel_nxt = {func[FC_VEL_SRC_B1], func[FC_VEL_SRC_B0]}; // see R02
        frc_nxt = {func[FC_FORCE_SRC_B1],
                   func[FC_FORCE_SRC_B0]}; // see R03
        tgt_nxt = {func[FC_TARGET_SEL_B2], func[FC_TARGET_SEL_B1],
                   func[FC_TARGET_SEL_B0]}; // see R13
        alarm_nxt = {~func[FC_FORWARD_TRAVEL_LIMIT],
                     ~func[FC_REVERSE_TRAVEL_LIMIT],
                     ~func[FC_OPERATIONAL_HALT]}; // see R14

        stored_nxt = 1'b0;
        loop_nxt = LOOP_POSITION;
        unique case (base_mode_i)
            MODE_PT: begin
                stored_nxt = func[FC_PULSE_OR_STORED_SW]; // see R04
            end
            MODE_PR: begin
                stored_nxt = 1'b1; // see R04
            end
            MODE_S, MODE_SZ: begin
                loop_nxt = LOOP_SPEED;
            end
            MODE_T, MODE_TZ: begin
                loop_nxt = LOOP_TORQUE;
            end
            MODE_PT_S, MODE_PR_S: begin
                stored_nxt = (base_mode_i == MODE_PR_S);
                loop_nxt = func[FC_SPEED_POS_SW] ? LOOP_POSITION
                                                 : LOOP_SPEED; // see R12
            end
            MODE_PT_T, MODE_PR_T: begin
                stored_nxt = (base_mode_i == MODE_PR_T);
                loop_nxt = func[FC_TORQUE_POS_SW] ? LOOP_POSITION
                                                  : LOOP_TORQUE; // see R12
            end
            MODE_S_T: begin
                loop_nxt = func[FC_SPEED_TORQUE_SW] ? LOOP_TORQUE
                                                    : LOOP_SPEED; // see R12
            end
            default: begin
                loop_nxt = LOOP_POSITION;
            end
        endcase

        pos_mode = (loop_nxt == LOOP_POSITION);
        gear_nxt = pos_mode ? {func[FC_GEAR_NUM_SEL_B1],
                               func[FC_GEAR_NUM_SEL_B0]}
                            : gear_r; // see R10
        mot_nxt = {
            pos_mode && !stored_nxt
                && func[FC_PULSE_INPUT_BLOCK],           // see R09
            func[FC_INCH_REVERSE],                       // see R08
            func[FC_INCH_FORWARD],                       // see R07
            pos_mode && stored_nxt
                && func[FC_GO_TO_ORIGIN],                // see R06
            force_limit_enable_param_i
                && func[FC_FORWARD_FORCE_LIMIT],         // see R05
            force_limit_enable_param_i
                && func[FC_REVERSE_FORCE_LIMIT]          // see R05
        };
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags_r <= '0;
            vel_r <= SEL2_RESET;
            frc_r <= SEL2_RESET;
            gear_r <= SEL2_RESET;
            tgt_r <= SEL3_RESET;
            alarm_r <= ALARM_RESET;
            stored_r <= 1'b0;
            loop_r <= LOOP_POSITION;
            mot_r <= '0;
        end else if (ce_i) begin
            flags_r <= flags_nxt;
            vel_r <= vel_nxt;
            frc_r <= frc_nxt;
            gear_r <= gear_nxt;
            tgt_r <= tgt_nxt;
            alarm_r <= alarm_nxt;
            stored_r <= stored_nxt;
            loop_r <= loop_nxt;
            mot_r <= mot_nxt;
        end
    end

    assign servo_enable_o = flags_r[0];
    assign fault_clear_o = flags_r[1];
    assign gain_switch_o = flags_r[2];
    assign pulse_counter_clear_o = flags_r[3];
    assign low_speed_hold_o = flags_r[4];
    assign command_direction_invert_o = flags_r[5];
    assign command_trigger_o = flags_r[6];
    assign torque_limit_enable_o = flags_r[7];
    assign speed_limit_enable_o = flags_r[8];
    assign motor_stop_o = flags_r[9];
    assign origin_sensor_o = flags_r[10];
    assign velocity_source_sel_o = vel_r;
    assign force_source_sel_o = frc_r;
    assign stored_target_sel_o = tgt_r;
    assign gear_numerator_sel_o = gear_r;
    assign stored_target_mode_o = stored_r;
    assign active_loop_o = loop_r;
    assign reverse_force_limit_o = mot_r[0];
    assign forward_force_limit_o = mot_r[1];
    assign go_to_origin_o = mot_r[2];
    assign inch_forward_o = mot_r[3];
    assign inch_reverse_o = mot_r[4];
    assign pulse_input_block_o = mot_r[5];
    assign alarm_o = alarm_r;

endmodule // difm_mapper

`default_nettype wire

//--- verif/difm_ext_ctrl.sv
// model of the switches driving the mapper inputs
// assumes: bench changes requests just after a falling edge
`default_nettype none
module difm_ext_ctrl (
    // requested levels
    input wire logic [7:0] want_i,
    // normally closed contacts
    input wire logic [7:0] nc_i,
    // physical input pins
    output logic [7:0] din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // assigned pins follow request, closed contacts stay on
    assign din_o = want_i | nc_i;
endmodule // difm_ext_ctrl
`default_nettype wire

//--- verif/difm_mapper_assertions.sv
// port checks of the input mapper
// assumes: ce_i high, codes, mode, param change only in reset
`default_nettype none
module difm_chk
    import difm_pkg::*;
#(
    parameter int NUM_IN = DIFM_NUM_IN
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // inputs and configuration
    input wire logic [NUM_IN-1:0] din_i,
    input wire logic [NUM_IN*DIFM_CODE_W-1:0] assign_codes_i,
    input wire difm_mode_t base_mode_i,
    input wire logic force_limit_enable_param_i,
    // outputs
    input wire logic servo_enable_o,
    input wire logic [1:0] velocity_source_sel_o,
    input wire logic stored_target_mode_o,
    input wire logic reverse_force_limit_o,
    input wire logic inch_forward_o,
    input wire logic inch_reverse_o,
    input wire logic go_to_origin_o,
    input wire logic [2:0] alarm_o
);
    logic [1:0] age_r, age_nxt;
    logic [3*NUM_IN-1:0] dh_r, dh_nxt;
    logic [NUM_IN-1:0] d3;
    logic ok;
    // d3 is the input level that the outputs show now
    always_comb begin
        age_nxt = rst_i ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
        dh_nxt = {dh_r[2*NUM_IN-1:0], din_i};
        d3 = dh_r[3*NUM_IN-1-:NUM_IN];
        ok = age_r == 2'h3;
    end
    always_ff @(posedge clock_i) begin
        age_r <= age_nxt;
        dh_r <= dh_nxt;
    end
    function automatic logic h(logic [7:0] c, logic [NUM_IN-1:0] d);
        h = 1'b0;
        for (int k = 0; k < NUM_IN; k++) begin
            h |= d[k] && assign_codes_i[8*k+:8] == c;
        end
    endfunction
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);
    servo_on_a:
    assert property (ok |-> servo_enable_o == h(8'h01, d3))
        else $error("servo enable wrong");
    speed_src_a:
    assert property (ok |-> velocity_source_sel_o ==
        {h(8'h15, d3), h(8'h14, d3)}) else $error("speed source wrong");
    force_gate_a:
    assert property (ok |-> reverse_force_limit_o == (h(8'h25, d3)
        && $past(force_limit_enable_param_i))) else $error("gate wrong");
    inch_dir_a:
    assert property (ok |-> {inch_forward_o, inch_reverse_o} ==
        {h(8'h37, d3), h(8'h38, d3)}) else $error("inch wrong");
    travel_alarm_a:
    assert property (ok |-> alarm_o == {!h(8'h23, d3), !h(8'h22, d3),
        !h(8'h21, d3)}) else $error("alarm wrong");
    stored_sel_a:
    assert property (ok && base_mode_i == MODE_PT |->
        stored_target_mode_o == h(8'h2A, d3)) else $error("mode wrong");
    home_move_a:
    assert property (ok && base_mode_i == MODE_PR |->
        go_to_origin_o == h(8'h27, d3)) else $error("home wrong");
    quiet_start_a:
    // empty sync chain reads as all contacts open one edge later
    assert property ($fell(rst_i) |-> alarm_o == 3'h0 ##1 alarm_o == 3'h7)
        else $error("alarm before sync");
    cover property (ok && stored_target_mode_o);
    cover property (ok && |alarm_o);
    cover property (ok && go_to_origin_o);
endmodule // difm_chk
bind difm_mapper difm_chk #(.NUM_IN(NUM_IN)) i_difm_chk (
    .clock_i, .rst_i, .ce_i, .din_i, .assign_codes_i, .base_mode_i,
    .force_limit_enable_param_i, .servo_enable_o, .velocity_source_sel_o,
    .stored_target_mode_o, .reverse_force_limit_o, .inch_forward_o,
    .inch_reverse_o, .go_to_origin_o, .alarm_o);
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench of the input mapper
// assumes: package, mapper, checker and switch model compiled first
`default_nettype none
module tb_top;
    import difm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] BC [11] = '{8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h08, 8'h09, 8'h10, 8'h46, 8'h24};
    // per test: codes, mode, force limit parameter
    localparam logic [63:0] CODS [7] = '{64'h2144_4345_272A_0201,
        64'h2226_2517_1615_1418, 64'h2338_3726_2513_1211,
        64'h2406_0403_08FF_0701, 64'h2625_0101_4610_0905,
        64'h2027_4345_2003_1716, 64'h1905_1918_2022_2123};
    localparam difm_mode_t MDS [7] = '{MODE_PT, MODE_PT_S, MODE_PR,
        MODE_PT, MODE_PT, MODE_PT_T, MODE_S_T};
    localparam logic [6:0] PAR = 7'h2D;
    logic ce = 1'b1;
    logic [10:0] hold;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] want = 8'h00;
    logic [7:0] nc = 8'h00;
    logic [7:0] din;
    logic [63:0] codes = CODS[0];
    difm_mode_t mode = MODE_PT;
    logic par = 1'b1;
    logic [7:0] hst [3] = '{8'h00, 8'h00, 8'h00};
    logic [10:0] bas;
    logic [1:0] vel, frc, gear;
    logic [2:0] tgt, alm;
    logic stm, rfl, ffl, goo, ifw, irv, pib;
    difm_loop_t lp;
    int fails = 0;
    int tests_run = 0;
    integer seed = 32'h7f24f937;
    difm_ext_ctrl i_difm_ext_ctrl (.want_i(want), .nc_i(nc), .din_o(din));
    difm_mapper i_difm_mapper (
        .clock_i, .rst_i, .ce_i(ce), .din_i(din),
        .assign_codes_i(codes), .base_mode_i(mode),
        .force_limit_enable_param_i(par),
        .servo_enable_o(bas[0]), .fault_clear_o(bas[1]),
        .gain_switch_o(bas[2]), .pulse_counter_clear_o(bas[3]),
        .low_speed_hold_o(bas[4]), .command_direction_invert_o(bas[5]),
        .command_trigger_o(bas[6]), .torque_limit_enable_o(bas[7]),
        .speed_limit_enable_o(bas[8]), .motor_stop_o(bas[9]),
        .origin_sensor_o(bas[10]), .velocity_source_sel_o(vel),
        .force_source_sel_o(frc), .stored_target_sel_o(tgt),
        .gear_numerator_sel_o(gear), .stored_target_mode_o(stm),
        .active_loop_o(lp), .reverse_force_limit_o(rfl),
        .forward_force_limit_o(ffl), .go_to_origin_o(goo),
        .inch_forward_o(ifw), .inch_reverse_o(irv),
        .pulse_input_block_o(pib), .alarm_o(alm));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    function automatic logic h(logic [7:0] c, logic [7:0] d);
        h = 1'b0;
        for (int k = 0; k < 8; k++) begin
            h |= d[k] && codes[8*k+:8] == c;
        end
    endfunction
    // loop in force for the configured mode and switch inputs
    function automatic difm_loop_t elp(logic [7:0] d);
        case (mode)
            MODE_S, MODE_SZ: elp = LOOP_SPEED;
            MODE_T, MODE_TZ: elp = LOOP_TORQUE;
            MODE_PT_S, MODE_PR_S: elp = h(8'h18, d) ? LOOP_POSITION
                                                    : LOOP_SPEED;
            MODE_PT_T, MODE_PR_T: elp = h(8'h20, d) ? LOOP_POSITION
                                                    : LOOP_TORQUE;
            MODE_S_T: elp = h(8'h19, d) ? LOOP_TORQUE : LOOP_SPEED;
            default: elp = LOOP_POSITION;
        endcase
    endfunction
    // pins carrying halt or travel limits idle closed
    function automatic logic [7:0] ncm(logic [63:0] cv);
        for (int k = 0; k < 8; k++) begin
            ncm[k] = cv[8*k+:8] inside {8'h21, 8'h22, 8'h23};
        end
    endfunction
    task chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // outputs show the level driven three falling edges ago
    task step(input logic on, input logic [7:0] ncv);
        logic [7:0] d;
        logic [10:0] eb;
        logic pos, st;
        @(negedge clock_i);
        d = hst[2];
        for (int i = 0; i < 11; i++) begin
            eb[i] = h(BC[i], d);
        end
        pos = elp(d) == LOOP_POSITION;
        st = mode == MODE_PR || mode == MODE_PT && h(8'h2A, d);
        if (on) begin
            chk(bas, eb);
            chk(vel, {h(8'h15, d), h(8'h14, d)});
            chk(frc, {h(8'h17, d), h(8'h16, d)});
            chk(stm, st);
            chk({rfl, ffl}, {h(8'h25, d), h(8'h26, d)} & {2{par}});
            chk(goo, h(8'h27, d) && pos && st);
            chk({ifw, irv}, {h(8'h37, d), h(8'h38, d)});
            chk(pib, h(8'h45, d) && pos && !st);
            chk(lp, elp(d));
            chk(tgt, {h(8'h13, d), h(8'h12, d), h(8'h11, d)});
            chk(alm, {!h(8'h23, d), !h(8'h22, d), !h(8'h21, d)});
            if (pos) begin
                chk(gear, {h(8'h44, d), h(8'h43, d)});
            end
        end
        hst[2] = hst[1];
        hst[1] = hst[0];
        nc = ncv;
        want = 8'($random(seed));
        hst[0] = want | ncv;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        fails++;
        end_sim;
    end
    initial begin
        for (int c = 0; c < 7; c++) begin
            rst_i = 1'b1;
            codes = CODS[c];
            mode = MDS[c];
            par = PAR[c];
            repeat (3) step(1'b0, 8'h00);
            rst_i = 1'b0;
            repeat (2) step(1'b0, 8'h00);
            repeat (100) step(1'b1, ncm(codes));
            repeat (100) step(1'b1, 8'h00);
            $display("test %0d done", c);
        end
        // clock enable low must hold the eleven basic function outputs
        @(negedge clock_i);
        hold = bas;
        ce = 1'b0;
        want = ~want;
        repeat (4) @(negedge clock_i);
        chk(bas, hold);
        $display("freeze test done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
